/* File: bench/sarsr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sarsr_host_model (
  input wire logic ref_clk,
  input wire logic line,
  output logic convert_start,
  output logic serial_in_select,
  output logic serial_clk
);
  initial begin
    convert_start = 1'b0;
    serial_in_select = 1'b1;
    serial_clk = 1'b0;
  end
  task automatic pins(input logic c, s, k, input int n);
    repeat (n) @(posedge ref_clk);
    #1;
    convert_start = c;
    serial_in_select = s;
    serial_clk = k;
  endtask
  // The clock runs only in a frame or for the reset falls; a bit is taken just before the
  // next fall, a full period after launch, so slow updates still pass.
  task automatic read(input int n, output logic [16:0] w);
    w = 17'h00000;
    #13;
    repeat (n) begin
      serial_clk = 1'b1;
      #32;
      w = {w[15:0], line};
      serial_clk = 1'b0;
      #32;
    end
  endtask
endmodule // sarsr_host_model
`default_nettype wire

/* File: bench/sarsr_readout_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module sarsr_readout_sva #(
  parameter int DATA_W = 16,
  parameter int CONV_CYCLES = 168
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic serial_clk,
  input wire logic convert_start,
  input wire logic serial_in_select,
  input wire logic [DATA_W-1:0] sample_code,
  input wire logic over_range,
  input wire logic under_range,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  input wire logic power_down
);
  logic [9:0] low_cnt;
  logic [3:0] since;
  logic sel_mode, sclk_hi;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Pins are taken as they stood before the rise, as the older sync stage.
  always_ff @(posedge ref_clk) begin
    low_cnt <= power_down ? 10'h000 : low_cnt + 10'h001;
    since <= $fell(serial_clk) ? 4'h0 : since + 4'(since != 4'hf);
    if ($rose(convert_start) && power_down) begin
      sel_mode <= $past(serial_in_select);
      sclk_hi <= $past(serial_clk);
    end
  end
  a_start_conv: assert property (
    $rose(convert_start) && power_down && $past(serial_in_select)
    |-> ##[1:6] (!power_down && serial_out_oe_n)) else $error("start");
  a_conv_len: assert property (
    $rose(power_down) |-> low_cnt >= 10'(CONV_CYCLES - 1)
    && low_cnt <= 10'(CONV_CYCLES + 1)) else $error("length");
  a_busy_low: assert property (
    $rose(power_down) && sel_mode && !convert_start
    |-> ##[0:3] (!serial_out_oe_n && !serial_out)) else $error("busy");
  a_nobusy_float: assert property (
    $rose(power_down) && sel_mode && convert_start && serial_in_select
    |-> serial_out_oe_n [*3]) else $error("float");
  a_chain_busy: assert property (
    $rose(power_down) && !sel_mode && sclk_hi
    |-> ##[0:3] (!serial_out_oe_n && serial_out)) else $error("chain busy");
  a_chain_drive: assert property (
    $rose(power_down) && !sel_mode && !sclk_hi
    |-> ##[0:3] !serial_out_oe_n) else $error("chain");
  a_both_low: assert property (
    (!convert_start && !serial_in_select && power_down) [*6]
    |-> !serial_out_oe_n && !serial_out) else $error("both low");
  a_bit_hold: assert property (
    !serial_out_oe_n && !$past(serial_out_oe_n) && $changed(serial_out)
    |-> since < 4'h8) else $error("hold");
endmodule // sarsr_readout_sva
bind sarsr_readout sarsr_readout_sva #(.DATA_W(DATA_W),
  .CONV_CYCLES(CONV_CYCLES)) i_sva (.ref_clk(ref_clk), .reset(reset),
  .serial_clk(serial_clk), .convert_start(convert_start),
  .serial_in_select(serial_in_select), .sample_code(sample_code),
  .over_range(over_range), .under_range(under_range),
  .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
  .power_down(power_down));
`default_nettype wire

/* File: bench/sarsr_readout_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sarsr_readout_tb;
  localparam int CONV = 20;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] code = 16'h0000;
  logic over = 1'b0, under = 1'b0;
  logic [16:0] w;
  int n_mismatch = 0;
  int checks_done = 0;
  wire logic start, sel, sclk, dout, oe_n, pd;
  // The line has a pull-up, so a floating output reads high.
  wire logic line = oe_n ? 1'b1 : dout;
  always #4 ref_clk = ~ref_clk;
  sarsr_readout #(.CONV_CYCLES(CONV)) i_sarsr_readout (.ref_clk(ref_clk),
    .reset(reset), .serial_clk(sclk), .convert_start(start),
    .serial_in_select(sel), .sample_code(code), .over_range(over),
    .under_range(under), .serial_out(dout), .serial_out_oe_n(oe_n),
    .power_down(pd));
  sarsr_host_model i_sarsr_host_model (.ref_clk(ref_clk), .line(line),
    .convert_start(start), .serial_in_select(sel), .serial_clk(sclk));
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic pin(input logic c, s, k, input int n);
    i_sarsr_host_model.pins(c, s, k, n);
  endtask
  task automatic rd(input int n);
    wt(8);
    i_sarsr_host_model.read(n, w);
    wt(8);
  endtask
  task automatic cmp(input logic [16:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_sel3();
    code = 16'h8001;
    pin(1, 1, 0, 1);
    pin(0, 1, 0, 6);
    cmp({15'h0, pd, oe_n}, 17'h00001);
    pin(1, 1, 0, 2);
    pin(0, 1, 0, CONV);
    rd(16);
    cmp(w, 17'h08001);
    cmp({16'h0, line}, 17'h00001);
  endtask
  task automatic t_busy3();
    over = 1'b1;
    pin(1, 1, 0, 1);
    pin(0, 1, 0, 2);
    cmp({16'h0, line}, 17'h00001);
    wt(CONV + 6);
    cmp({16'h0, line}, 17'h00000);
    rd(17);
    cmp(w, 17'h07fff);
    cmp({16'h0, line}, 17'h00001);
    over = 1'b0;
  endtask
  task automatic t_4w();
    under = 1'b1;
    pin(0, 0, 0, 1);
    wt(8);
    cmp({15'h0, oe_n, dout}, 17'h00000);
    pin(0, 1, 0, 1);
    pin(1, 1, 0, 4);
    pin(1, 0, 0, 2);
    pin(1, 1, 0, 2);
    pin(1, 0, 0, CONV + 4);
    rd(4);
    cmp(w, 17'h00008);
    pin(1, 1, 0, 1);
    wt(8);
    cmp({16'h0, line}, 17'h00001);
    under = 1'b0;
  endtask
  task automatic t_chain();
    code = 16'h1234;
    for (int b = 0; b < 2; b++) begin
      pin(0, 0, b[0], 1);
      pin(1, !b[0], b[0], 4);
      wt(CONV + 8);
      rd(16 + b);
      cmp(w, {b[0], 16'h1234});
      cmp({16'h0, line}, 17'h00001);
    end
  endtask
  initial begin
    i_sarsr_host_model.read(4, w);
    wt(1);
    reset = 1'b0;
    // The link side lets go of reset only after three more falls.
    i_sarsr_host_model.read(3, w);
    t_sel3();
    t_busy3();
    t_4w();
    t_chain();
    final_report();
  end
  initial begin
    #40000;
    n_mismatch++;
    final_report();
  end
endmodule // sarsr_readout_tb
`default_nettype wire

/* File: hw/sarsr_link_cnt.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sarsr_map.svh"

// Counts serial clock falling edges on the serial clock itself.
module sarsr_link_cnt (
  input wire logic serial_clk,
  input wire logic reset,
  sarsr_link_if.link lnk
);

  logic [2:0] rst_sync;
  logic [`SARSR_CNT_W-1:0] fall_bin;
  wire logic [`SARSR_CNT_W-1:0] next_fall_bin;
  wire logic link_reset;

  assign link_reset = rst_sync[2];
  assign next_fall_bin = fall_bin + `SARSR_CNT_W'(1);

  // The serial clock may stand still, so reset only lands while it runs.
  always_ff @(negedge serial_clk) begin
    rst_sync <= {rst_sync[1:0], reset};
  end

  always_ff @(negedge serial_clk) begin
    if (link_reset) begin
      fall_bin <= 6'h00;
      lnk.fall_gray <= 6'h00;
    end else begin
      fall_bin <= next_fall_bin;
      lnk.fall_gray <= next_fall_bin ^ (next_fall_bin >> 1);
    end
  end

endmodule // sarsr_link_cnt

`default_nettype wire

/* File: hw/sarsr_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface sarsr_link_if;
  logic [5:0] fall_gray;
  modport link (output fall_gray);
  modport core (input fall_gray);
endinterface

`default_nettype wire

/* File: hw/sarsr_map.svh */
`ifndef SARSR_MAP_SVH
`define SARSR_MAP_SVH

// Reference clock rate and the conversion time window.
`define SARSR_REF_CLK_MHZ 125
`define SARSR_CONV_MIN_NS 500
`define SARSR_CONV_MAX_NS 2200
// Least time rounds up, longest time rounds down.
`define SARSR_CONV_MIN_CYC \
  ((`SARSR_CONV_MIN_NS * `SARSR_REF_CLK_MHZ + 999) / 1000)
`define SARSR_CONV_MAX_CYC \
  ((`SARSR_CONV_MAX_NS * `SARSR_REF_CLK_MHZ) / 1000)
`define SARSR_CONV_CYC ((`SARSR_CONV_MIN_CYC + `SARSR_CONV_MAX_CYC) / 2)

// Result word layout and saturation codes.
`define SARSR_DATA_W 16
`define SARSR_CODE_POS_FS 16'h7fff
`define SARSR_CODE_NEG_FS 16'h8000
`define SARSR_CODE_RESET 16'h0000

// Serial clock falling edge counter width and frame ends.
`define SARSR_CNT_W 6
`define SARSR_END_PLAIN 6'h10
`define SARSR_END_BUSY 6'h11

`endif

/* File: hw/sarsr_pkg.sv */
package sarsr_pkg;

  typedef enum logic [1:0] {
    st_acq,
    st_conv,
    st_read
  } sarsr_state_t;

  typedef enum logic {
    mode_chain,
    mode_select
  } sarsr_mode_t;

  function automatic logic [5:0] sarsr_gray2bin(input logic [5:0] g);
    logic [5:0] b;
    b[5] = g[5];
    for (int i = 4; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction

endpackage

/* File: hw/sarsr_readout.sv */
// Overview of operation
// - Serial select input level at conversion start rise picks select/chain.
// - Tied select and start pins resolve to chain mode unless already high as reset ends.
// - Optional start bit flags busy; otherwise host waits maximum time.
// - Select mode: busy bit enabled if start or select low at end.
// - Chain mode: busy bit enabled only if serial clock high at rise.
// - Rise with select high starts conversion, select mode, output floats.
// - A started conversion completes regardless of the start pin.
// - Completion moves to read-out and powers down without a command.
// - 3-wire no-busy: start falling drives MSB; clock falls shift on.
// - Each bit holds across both serial clock edges.
// - 3-wire no-busy: float at 16th falling edge or start rise.
// - 3-wire busy: float until done, then drive low start bit.
// - 3-wire busy: MSB first on falls, float at 17th or start rise.
// - Output tolerates contention; host keeps overlap short.
// - Both select and start low drives the output low.
// - 4-wire no-busy: select falling drives MSB; falls shift on.
// - 4-wire no-busy: float at 16th falling edge or select rise.
// - Result is 16-bit two's complement, saturating at both full scales.
// - Conversion timed by internal clock, never by serial clock.
`timescale 1ns/1ps
`default_nettype none
`include "sarsr_map.svh"

module sarsr_readout #(
  parameter int DATA_W = `SARSR_DATA_W,
  parameter int CONV_CYCLES = `SARSR_CONV_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic serial_clk,
  input wire logic convert_start,
  input wire logic serial_in_select,
  input wire logic [DATA_W-1:0] sample_code,
  input wire logic over_range,
  input wire logic under_range,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic power_down
);

  localparam logic [11:0] CONV_LAST = 12'(CONV_CYCLES - 1);

  sarsr_link_if lnk ();

  sarsr_link_cnt u_link (
    .serial_clk(serial_clk),
    .reset(reset),
    .lnk(lnk.link)
  );

  // Pin synchronisers, three stages each.
  logic [2:0] cnv_s;
  logic [2:0] sdi_s;
  logic [2:0] sck_s;
  logic [5:0] gray_s1;
  logic [5:0] gray_s2;
  logic [5:0] gray_s3;
  logic [5:0] fall_cnt;

  sarsr_pkg::sarsr_state_t state;
  sarsr_pkg::sarsr_state_t next_state;
  sarsr_pkg::sarsr_mode_t mode;
  logic [11:0] conv_cnt;
  logic busy_en;
  logic [DATA_W-1:0] held_code;
  logic [DATA_W-1:0] result;
  logic [5:0] base;
  logic out_on;
  logic out_done;

  wire logic cnv_lvl;
  wire logic sdi_lvl;
  wire logic cnv_rise;
  wire logic conv_end;
  wire logic both_low;
  wire logic both_high;
  wire logic [5:0] delta;
  wire logic [5:0] end_cnt;
  wire logic [5:0] bit_idx;
  wire logic data_bit;
  wire logic start_bit;
  wire logic frame_start;
  wire logic frame_stop;
  wire logic [DATA_W-1:0] sat_code;
  wire logic next_busy_sel;
  wire logic next_out_bit;
  wire logic next_oe_n;

  assign cnv_lvl = cnv_s[2];
  assign sdi_lvl = sdi_s[2];
  assign cnv_rise = cnv_s[1] & ~cnv_s[2];
  assign both_low = ~cnv_lvl & ~sdi_lvl;
  assign both_high = cnv_lvl & sdi_lvl;
  assign conv_end = (state == sarsr_pkg::st_conv) &&
                    (conv_cnt == CONV_LAST);

  assign sat_code = over_range ? `SARSR_CODE_POS_FS :
                    under_range ? `SARSR_CODE_NEG_FS :
                    sample_code;

  assign next_busy_sel = ~cnv_lvl | ~sdi_lvl;

  assign delta = fall_cnt - base;
  assign end_cnt = busy_en ? `SARSR_END_BUSY : `SARSR_END_PLAIN;
  assign bit_idx = busy_en ? delta - 6'h01 : delta;
  assign start_bit = (mode == sarsr_pkg::mode_chain);
  assign data_bit = (bit_idx < 6'(DATA_W)) ?
                    result[4'(DATA_W - 1) - bit_idx[3:0]] : 1'b0;

  // A chain frame opens once read-out starts; a select frame without busy opens when the host selects the part.
  assign frame_start = (state == sarsr_pkg::st_read) && !out_on &&
                       !out_done &&
                       ((mode == sarsr_pkg::mode_chain) ||
                        (!busy_en && next_busy_sel));

  assign frame_stop = out_on &&
                      ((delta >= end_cnt) ||
                       ((mode == sarsr_pkg::mode_select) && both_high) ||
                       ((mode == sarsr_pkg::mode_chain) && !cnv_lvl));

  assign next_out_bit = (out_on && busy_en && delta == 6'h00) ?
                        start_bit : (out_on ? data_bit : 1'b0);
  // Outside a frame the line floats unless both pins are low.
  assign next_oe_n = (state == sarsr_pkg::st_read && out_on) ? frame_stop :
                     !both_low;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnv_s <= 3'h0;
      // The select pin idles high, so a cleared stage would fake both-low.
      sdi_s <= 3'h7;
      sck_s <= 3'h0;
    end else begin
      cnv_s <= {cnv_s[1:0], convert_start};
      sdi_s <= {sdi_s[1:0], serial_in_select};
      sck_s <= {sck_s[1:0], serial_clk};
    end
  end

  // Gray count is taken only when the last two stages agree.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gray_s1 <= 6'h00;
      gray_s2 <= 6'h00;
      gray_s3 <= 6'h00;
      fall_cnt <= 6'h00;
    end else begin
      gray_s1 <= lnk.fall_gray;
      gray_s2 <= gray_s1;
      gray_s3 <= gray_s2;
      if (gray_s2 == gray_s3) begin
        fall_cnt <= sarsr_pkg::sarsr_gray2bin(gray_s3);
      end
    end
  end

  // A start rise during conversion is ignored, so a conversion always ends.
  always_comb begin
    next_state = state;
    unique case (state)
      sarsr_pkg::st_acq: begin
        if (cnv_rise) begin
          next_state = sarsr_pkg::st_conv;
        end
      end
      sarsr_pkg::st_conv: begin
        if (conv_end) begin
          next_state = sarsr_pkg::st_read;
        end
      end
      sarsr_pkg::st_read: begin
        if (cnv_rise) begin
          next_state = sarsr_pkg::st_conv;
        end else if (frame_stop) begin
          next_state = sarsr_pkg::st_acq;
        end
      end
      default: begin
        next_state = sarsr_pkg::st_acq;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= sarsr_pkg::st_acq;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || state != sarsr_pkg::st_conv) begin
      conv_cnt <= 12'h000;
    end else begin
      conv_cnt <= conv_cnt + 12'h001;
    end
  end

  // The older select sample wins, so tied pins read low at the rise.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode <= sarsr_pkg::mode_chain;
      busy_en <= 1'b0;
      held_code <= `SARSR_CODE_RESET;
    end else if (cnv_rise && state != sarsr_pkg::st_conv) begin
      mode <= sdi_s[2] ? sarsr_pkg::mode_select :
              sarsr_pkg::mode_chain;
      busy_en <= sck_s[2];
      held_code <= sat_code;
    end else if (conv_end && mode == sarsr_pkg::mode_select) begin
      busy_en <= next_busy_sel;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      result <= `SARSR_CODE_RESET;
    end else if (conv_end) begin
      result <= held_code;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || cnv_rise) begin
      out_on <= 1'b0;
      out_done <= 1'b0;
      base <= 6'h00;
    end else if (conv_end && mode == sarsr_pkg::mode_select &&
                 next_busy_sel) begin
      out_on <= 1'b1;
      base <= fall_cnt;
    end else if (frame_start) begin
      out_on <= 1'b1;
      base <= fall_cnt;
    end else if (frame_stop) begin
      out_on <= 1'b0;
      out_done <= 1'b1;
    end
  end

  // Output bit and enable come from flops; a bit changes only after a
  // falling edge, so it stands until the next falling edge.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      serial_out <= 1'b0;
      serial_out_oe_n <= 1'b1;
    end else begin
      serial_out <= next_out_bit;
      serial_out_oe_n <= next_oe_n;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      power_down <= 1'b1;
    end else begin
      power_down <= (state != sarsr_pkg::st_conv);
    end
  end

endmodule // sarsr_readout

`default_nettype wire
